// File: design/pprm_pkg.sv
// shared constants and types for the peripheral pin remap block
package pprm_pkg;
   localparam int unsigned PPRM_NPINS      = 32;            // remappable pins, four groups of eight
   localparam int unsigned PPRM_NGROUPS    = 4;             // pin and input groups
   localparam int unsigned PPRM_NINPUTS    = 24;            // remappable peripheral inputs
   localparam int unsigned PPRM_SEL_W      = 4;             // select field width
   localparam int unsigned PPRM_NPERIPH    = 16;            // peripheral output lines
   // byte offsets on the bus
   localparam logic [9:0]  PPRM_CFG_OFS    = 10'h000;       // system_config_reg
   localparam logic [9:0]  PPRM_BOOT_OFS   = 10'h004;       // boot_config_word3 image, read only
   localparam logic [9:0]  PPRM_ANA_OFS    = 10'h008;       // analog use per pin
   localparam logic [9:0]  PPRM_CPC_OFS    = 10'h00C;       // converter_pin_config_reg
   localparam logic [9:0]  PPRM_DIR_OFS    = 10'h010;       // pin_direction_reg
   localparam logic [9:0]  PPRM_LAT_OFS    = 10'h014;       // port output data latch
   localparam logic [9:0]  PPRM_VAL_OFS    = 10'h018;       // pin_value_reg, read only
   localparam logic [9:0]  PPRM_INSEL_OFS  = 10'h100;       // peripheral_input_select[0..23]
   localparam logic [9:0]  PPRM_OUTSEL_OFS = 10'h200;       // pin_output_select[0..31]
   // field positions
   localparam int unsigned PPRM_LOCK_BIT   = 13;            // mapping_write_lock
   localparam int unsigned PPRM_ONCE_BIT   = 29;            // single_session_lock_cfg
   // reset values
   localparam logic        PPRM_LOCK_RST   = 1'b0;
   localparam logic [3:0]  PPRM_SEL_RST    = 4'h0;          // no connection for outputs; for inputs code 0 is pin 0 of the group
   localparam logic [31:0] PPRM_DIR_RST    = 32'hFFFF_FFFF; // all inputs
   localparam logic [31:0] PPRM_ZERO32     = 32'h0000_0000;
   localparam logic [3:0]  PPRM_SEL_MAXPIN = 4'h7;          // highest valid input code
   // output select codes
   localparam logic [3:0]  PPRM_OS_NONE    = 4'h0;
   // bus state
   typedef enum logic [0:0] {PPRM_IDLE = 1'b0, PPRM_ACK = 1'b1} pprm_bus_st_t;
   // digital peripheral output bundle: data and drive enable per line
   typedef struct packed {
      logic [15:0] data;
      logic [15:0] drive;
   } pprm_periph_out_t;
endpackage : pprm_pkg

// File: design/pprm_top.sv
// peripheral pin remap: select registers, lock, and pin override logic
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RL1 - 4-bit input select, codes 0-7 pick pins
// RL2 - input codes 8-15 connect nothing
// RL3 - four input groups, each own eight pins
// RL4 - per-pin 4-bit output select field
// RL5 - output code zero disconnects, reset zero
// RL6 - output codes decode per pin group
// RL7 - locked select writes ack, contents unchanged
// RL8 - lock is config bit 13, one blocks
// RL9 - software unlocks before touching lock bit
// RL10 - single-session config: lock sticks until reset; here only while once_cfg_i stays high
// RL11 - single-session bit defaults set
// RL12 - input peripheral never drives direction
// RL13 - pin value reads real level when digital
// RL14 - output peripheral data overrides port latch
// RL15 - peripheral tri-state releases pin driver
// RL16 - bidirectional peripheral forces output only when driving
// RL17 - analog use disables input, reads zero
// RL18 - analog output ignores direction bit
// RL19 - converter config bit one for digital use
// RL20 - remap beats digital, never analog
// RL21 - no default pin until assigned; input selects here reset to code 0, pin 0 of the group
// RL22 - unlock qualifier gates lock bit writes
module pprm_top
   import pprm_pkg::*;
#(
   parameter int unsigned NPINS  = PPRM_NPINS,
   parameter int unsigned NINPUT = PPRM_NINPUTS,
   parameter logic        ONCE_DEFAULT = 1'b1               // unprogrammed single-session bit
)
(
   // clock and reset
   input  wire  logic                   clk_i,
   input  wire  logic                   rst_i,
   input  wire  logic                   ce_i,
   // wishbone slave
   input  wire  logic                   wb_cyc_i,
   input  wire  logic                   wb_stb_i,
   input  wire  logic                   wb_we_i,
   input  wire  logic [9:0]             wb_adr_i,
   input  wire  logic [3:0]             wb_sel_i,
   input  wire  logic [31:0]            wb_dat_i,
   output logic [31:0]                  wb_dat_o,
   output logic                         wb_ack_o,
   // unlock and boot configuration
   input  wire  logic                   unlock_ok_i,
   input  wire  logic                   once_cfg_i,
   // peripherals
   input  wire  pprm_periph_out_t       periph_out_i,
   input  wire  logic [NPINS-1:0]       ana_out_i,
   input  wire  logic [NPINS-1:0]       ana_out_en_i,
   output logic [NINPUT-1:0]            periph_in_o,
   // pads
   input  wire  logic [NPINS-1:0]       pad_i,
   output logic [NPINS-1:0]             pad_o,
   output logic [NPINS-1:0]             pad_oe_n_o,
   output logic [NPINS-1:0]             pad_ana_o,
   output logic [NPINS-1:0]             pad_ibuf_en_o
);
   localparam int unsigned GPIN = NPINS / PPRM_NGROUPS;    // pins per group
   // per-pin override signals live inside the pin generate block below

   // registers
   // all state below is frozen while ce_i is low; reset still wins
   logic [PPRM_SEL_W-1:0] insel_q  [NINPUT];                // per-peripheral input select
   logic [PPRM_SEL_W-1:0] outsel_q [NPINS];                 // per-pin output select
   logic                  lock_q;                           // mapping_write_lock
   logic                  once_q;                           // single_session_lock_cfg image
   logic                  locked_once_q;                    // lock was set this reset
   logic [NPINS-1:0]      ana_q;                            // pin used by analog function
   logic [NPINS-1:0]      cpc_q;                            // converter_pin_config_reg
   logic [NPINS-1:0]      dir_q;                            // pin_direction_reg, 1 = input
   logic [NPINS-1:0]      lat_q;                            // port output latch
   logic [NPINS-1:0]      val_q;                            // pin_value_reg
   pprm_bus_st_t          bus_q;

   // bus decode
   // lane mask comes straight from the bus; request and write strobe are also gated by the idle state
   logic        req;
   logic        wr;
   logic [31:0] wmask;
   logic [31:0] rdata;
   logic        lock_wr_ok;
   logic        lock_next;
   // a request is taken only while the slave is idle, so the ack cycle
   // itself can never start a second transfer
   assign req   = wb_cyc_i & wb_stb_i & (bus_q == PPRM_IDLE);
   assign wr    = req & wb_we_i;
   assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign lock_next = wb_dat_i[PPRM_LOCK_BIT];

   // lock changes need unlock qualifier; clearing blocked after first set in single-session mode
   // hazard: once the single-session bit is set, a clear must not slip
   // through even with a valid unlock; setting again stays harmless
   always_comb
   begin
      lock_wr_ok = unlock_ok_i;                             // RL22 RL9
      if (once_q && locked_once_q && !lock_next)
      begin
         lock_wr_ok = 1'b0;                                 // RL10
      end
   end

   // bus handshake: one wait-free ack cycle, then idle
   // ack is a registered pulse; stb is ignored for the one ack cycle
   // before the next request is taken, which the idle state enforces
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         bus_q    <= PPRM_IDLE;
         wb_ack_o <= 1'b0;
      end
      else if (ce_i)
      begin
         case (bus_q)
            PPRM_IDLE:
            begin
               wb_ack_o <= req;
               bus_q    <= req ? PPRM_ACK : PPRM_IDLE;
            end
            PPRM_ACK:
            begin
               wb_ack_o <= 1'b0;
               bus_q    <= PPRM_IDLE;
            end
            default:
            begin
               wb_ack_o <= 1'b0;
               bus_q    <= PPRM_IDLE;
            end
         endcase
      end
   end

   // lock bit and single-session capture; strap caught after reset release
   // the single-session image follows the strap every enabled cycle, so a
   // strap change can still lift the clear block after the lock has been set
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         lock_q        <= PPRM_LOCK_RST;
         once_q        <= ONCE_DEFAULT;                     // RL11
         locked_once_q <= 1'b0;
      end
      else if (ce_i)
      begin
         once_q <= once_cfg_i;
         if (wr && wb_adr_i == PPRM_CFG_OFS && wb_sel_i[1] && lock_wr_ok)
         begin
            lock_q <= lock_next;                            // RL8
            if (lock_next)
            begin
               locked_once_q <= 1'b1;                       // RL10
            end
         end
      end
   end

   // select registers; writes while locked are acked but dropped
   // limitation: only byte lane 0 reaches a select field; a write with
   // lane 0 off is acked and changes nothing
   genvar gi;
   generate
      for (gi = 0; gi < NINPUT; gi++)
      begin : g_insel
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               insel_q[gi] <= PPRM_SEL_RST;                 // RL21
            end
            else if (ce_i && wr && !lock_q && wb_sel_i[0] &&
                     wb_adr_i == PPRM_INSEL_OFS + 10'(gi * 4))
            begin
               insel_q[gi] <= wb_dat_i[PPRM_SEL_W-1:0];     // RL7
            end
         end
      end
      for (gi = 0; gi < NPINS; gi++)
      begin : g_outsel
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               outsel_q[gi] <= PPRM_SEL_RST;                // RL5
            end
            else if (ce_i && wr && !lock_q && wb_sel_i[0] &&
                     wb_adr_i == PPRM_OUTSEL_OFS + 10'(gi * 4))
            begin
               outsel_q[gi] <= wb_dat_i[PPRM_SEL_W-1:0];    // RL7
            end
         end
      end
   endgenerate

   // port control registers with byte lanes
   // these registers are not covered by the mapping lock, only selects are
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ana_q <= '0;
         cpc_q <= '1;
         dir_q <= PPRM_DIR_RST[NPINS-1:0];
         lat_q <= '0;
      end
      else if (ce_i && wr)
      begin
         case (wb_adr_i)
            PPRM_ANA_OFS: ana_q <= (ana_q & ~wmask[NPINS-1:0]) | (wb_dat_i[NPINS-1:0] & wmask[NPINS-1:0]);
            PPRM_CPC_OFS: cpc_q <= (cpc_q & ~wmask[NPINS-1:0]) | (wb_dat_i[NPINS-1:0] & wmask[NPINS-1:0]);
            PPRM_DIR_OFS: dir_q <= (dir_q & ~wmask[NPINS-1:0]) | (wb_dat_i[NPINS-1:0] & wmask[NPINS-1:0]);
            PPRM_LAT_OFS: lat_q <= (lat_q & ~wmask[NPINS-1:0]) | (wb_dat_i[NPINS-1:0] & wmask[NPINS-1:0]);
            default:      ana_q <= ana_q;
         endcase
      end
   end

   // pin is analog when the converter config bit is clear or an analog function claims it
   // trade-off: a cleared converter bit is treated like an analog claim,
   // which keeps the digital buffer off even while the converter is idle
   logic [NPINS-1:0] is_ana;
   assign is_ana = ana_q | ~cpc_q | ana_out_en_i;           // RL19

   // output select decode per pin group
   // codes not listed for a group fall through to no connection, so a
   // reserved code can never reach a peripheral line
   function automatic logic [4:0] out_line(input int unsigned grp, input logic [3:0] code);
      // returns {valid, line index}; reserved codes give no connection
      logic [4:0] r;
      r = 5'h00;
      case (grp)
         0: case (code)
               4'h1: r = 5'h10;                             // uart1_transmit_out
               4'h2: r = 5'h11;                             // uart2_request_to_send_out
               4'h3: r = 5'h12;                             // spi1_slave_select_out
               4'h5: r = 5'h13;                             // output_compare1_out
               4'h7: r = 5'h14;                             // comparator2_out
               default: r = 5'h00;
            endcase
         1, 2: case (code)
               4'h3: r = 5'h15;                             // spi1_data_out
               4'h4: r = 5'h16;                             // spi2_data_out
               4'h5: r = 5'h17;                             // output_compare2_out
               default: r = 5'h00;
            endcase
         3: case (code)
               4'h3: r = 5'h15;                             // spi1_data_out
               4'h4: r = 5'h16;                             // spi2_data_out
               4'h5: r = 5'h18;                             // output_compare4_out
               4'h6: r = 5'h19;                             // output_compare5_out
               4'h7: r = 5'h1A;                             // reference_clock_out
               default: r = 5'h00;
            endcase
         default: r = 5'h00;
      endcase
      return r;
   endfunction : out_line

   // pad drive and pin value sampling per pin
   // analog output wins over everything, then an active remap, then the
   // port latch and direction bit; each pad flop loads every enabled cycle
   generate
      for (gi = 0; gi < NPINS; gi++)
      begin : g_pin
         logic [4:0] ln;
         logic       per_act;
         logic       per_drv;
         logic       per_dat;
         assign ln      = out_line(gi / GPIN, outsel_q[gi]); // RL4 RL6
         assign per_act = ln[4] && !is_ana[gi];              // RL20
         assign per_drv = per_act && periph_out_i.drive[ln[3:0]]; // RL15 RL16
         assign per_dat = periph_out_i.data[ln[3:0]];
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               pad_o[gi]         <= 1'b0;
               pad_oe_n_o[gi]    <= 1'b1;
               pad_ana_o[gi]     <= 1'b0;
               pad_ibuf_en_o[gi] <= 1'b0;
               val_q[gi]         <= 1'b0;
            end
            else if (ce_i)
            begin
               pad_ana_o[gi]     <= ana_out_en_i[gi] ? ana_out_i[gi] : 1'b0; // RL18
               pad_ibuf_en_o[gi] <= !is_ana[gi];                             // RL17
               val_q[gi]         <= is_ana[gi] ? 1'b0 : pad_i[gi];          // RL13 RL17
               if (ana_out_en_i[gi])
               begin
                  pad_oe_n_o[gi] <= 1'b1;                    // RL18
                  pad_o[gi]      <= 1'b0;
               end
               else if (per_act)
               begin
                  pad_oe_n_o[gi] <= !per_drv;                // RL14 RL15
                  pad_o[gi]      <= per_dat;                 // RL14
               end
               else
               begin
                  pad_oe_n_o[gi] <= dir_q[gi] | is_ana[gi];  // RL12
                  pad_o[gi]      <= lat_q[gi];
               end
            end
         end
      end
   endgenerate

   // peripheral input routing by group; reserved codes give zero
   // inputs read the sampled pin value, so a routed input lags the pad by
   // two enabled cycles and an analog pin always reads as zero
   generate
      for (gi = 0; gi < NINPUT; gi++)
      begin : g_in
         localparam int unsigned GRP = (gi * PPRM_NGROUPS) / NINPUT; // RL3
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               periph_in_o[gi] <= 1'b0;
            end
            else if (ce_i)
            begin
               if (insel_q[gi] <= PPRM_SEL_MAXPIN)          // RL1
               begin
                  periph_in_o[gi] <= val_q[GRP * GPIN + 32'(insel_q[gi][2:0])];
               end
               else
               begin
                  periph_in_o[gi] <= 1'b0;                   // RL2
               end
            end
         end
      end
   endgenerate

   // read mux
   // selects are searched by address; an unknown address reads zero
   always_comb
   begin
      rdata = PPRM_ZERO32;
      case (wb_adr_i)
         PPRM_CFG_OFS:  rdata[PPRM_LOCK_BIT] = lock_q;
         PPRM_BOOT_OFS: rdata[PPRM_ONCE_BIT] = once_q;
         PPRM_ANA_OFS:  rdata[NPINS-1:0] = ana_q;
         PPRM_CPC_OFS:  rdata[NPINS-1:0] = cpc_q;
         PPRM_DIR_OFS:  rdata[NPINS-1:0] = dir_q;
         PPRM_LAT_OFS:  rdata[NPINS-1:0] = lat_q;
         PPRM_VAL_OFS:  rdata[NPINS-1:0] = val_q;
         default:
         begin
            for (int i = 0; i < NINPUT; i++)
               if (wb_adr_i == PPRM_INSEL_OFS + 10'(i * 4))
                  rdata[PPRM_SEL_W-1:0] = insel_q[i];
            for (int i = 0; i < NPINS; i++)
               if (wb_adr_i == PPRM_OUTSEL_OFS + 10'(i * 4))
                  rdata[PPRM_SEL_W-1:0] = outsel_q[i];
         end
      endcase
   end

   // read data register, loaded with the ack
   // write cycles return zero so stale read data never lingers on the bus
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wb_dat_o <= PPRM_ZERO32;
      else if (ce_i && req)
         wb_dat_o <= wb_we_i ? PPRM_ZERO32 : rdata;
   end
endmodule : pprm_top
`default_nettype wire

// File: tb/pprm_checker.sv
// concurrent checks on the pin remap top ports
`timescale 1ns/1ps
`default_nettype none
module pprm_checker
   import pprm_pkg::*;
#(
   parameter int unsigned NPINS  = PPRM_NPINS,
   parameter int unsigned NINPUT = PPRM_NINPUTS
)
(
   // clock, reset and bus
   input wire logic              clk_i,
   input wire logic              rst_i,
   input wire logic              ce_i,
   input wire logic              wb_cyc_i,
   input wire logic              wb_stb_i,
   input wire logic              wb_we_i,
   input wire logic [9:0]        wb_adr_i,
   input wire logic [31:0]       wb_dat_o,
   input wire logic              wb_ack_o,
   // configuration and pads
   input wire logic              once_cfg_i,
   input wire logic [NPINS-1:0]  pad_i,
   input wire logic [NPINS-1:0]  pad_oe_n_o,
   input wire logic [NPINS-1:0]  pad_ibuf_en_o,
   input wire logic [NINPUT-1:0] periph_in_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic rd_ack; // read answer in this cycle
   assign rd_ack = wb_ack_o && !wb_we_i;
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held past one cycle");
   ack_timely_a: assert property (($rose(wb_cyc_i && wb_stb_i) && ce_i) |=> wb_ack_o)
      else $error("request not answered next cycle");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
      else $error("ack without request");
   // first edge after reset still shows reset state of the outputs
   reset_out_a: assert property ($fell(rst_i) |-> &pad_oe_n_o && periph_in_o == '0 && !wb_ack_o)
      else $error("outputs not idle after reset");
   unmapped_zero_a: assert property (rd_ack && wb_adr_i[9:8] == 2'b11 |-> wb_dat_o == '0)
      else $error("unmapped read not zero");
   // a pin with its input buffer off is analog and never driven digitally
   ana_no_drive_a: assert property ((~pad_ibuf_en_o & ~pad_oe_n_o) == '0)
      else $error("digital drive on analog pin");
   // read data was loaded one edge before the ack, from a value sampled one edge earlier still
   val_read_a: assert property (rd_ack && wb_adr_i == PPRM_VAL_OFS
      |-> wb_dat_o[NPINS-1:0] == ($past(pad_i, 2) & $past(pad_ibuf_en_o)))
      else $error("pin value read wrong");
   boot_read_a: assert property (rd_ack && wb_adr_i == PPRM_BOOT_OFS
      |-> wb_dat_o == {2'b00, $past(once_cfg_i, 2), 29'h0000_0000})
      else $error("boot word read wrong");
   lock_wr_c: cover property (wb_ack_o && wb_we_i && wb_adr_i == PPRM_CFG_OFS);
   val_rd_c: cover property (rd_ack && wb_adr_i == PPRM_VAL_OFS);
   ana_c: cover property (!pad_ibuf_en_o[3] && !pad_oe_n_o[4]);
endmodule : pprm_checker
`default_nettype wire

// File: tb/pprm_pad_model.sv
// pad side: resolves each pin from block drive and outside source
`timescale 1ns/1ps
`default_nettype none
module pprm_pad_model
   import pprm_pkg::*;
(
   // block side and outside level
   input  wire logic [31:0] pad_o_i,
   input  wire logic [31:0] oe_n_i,
   input  wire logic [31:0] ext_i,
   output logic [31:0]      pad_i_o
);
   // released pins follow the outside source, driven pins the block
   assign pad_i_o = (pad_o_i & ~oe_n_i) | (ext_i & oe_n_i);
endmodule : pprm_pad_model
`default_nettype wire

// File: tb/pprm_tb_top.sv
// self-checking bench for the pin remap block
`timescale 1ns/1ps
`default_nettype none
module pprm_tb_top
   import pprm_pkg::*;
;
   logic             clk_i = 1'b0;
   logic             rst_i = 1'b1;
   logic             cyc = 1'b0, stb = 1'b0, we = 1'b0, unlock = 1'b0, once = 1'b1, ce = 1'b1;
   logic [9:0]       adr = 10'h000;
   logic [31:0]      wdat = 32'h0000_0000, ext = 32'h0000_0000, ana_v = 32'h0000_0000, ana_en = 32'h0000_0000;
   logic [31:0]      rdat, dat_o, pad_in, pad_out, oe_n, ana, ibuf;
   logic             ack;
   logic [23:0]      pin;
   pprm_periph_out_t pout = '0;
   logic [3:0]       isel [24];
   logic [3:0]       osel [32];
   int               n_mismatch = 0, n_checks = 0;

   initial
   begin
      forever #25 clk_i = ~clk_i;
   end

   pprm_top u_pprm_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .unlock_ok_i(unlock), .once_cfg_i(once), .periph_out_i(pout), .ana_out_i(ana_v),
      .ana_out_en_i(ana_en), .periph_in_o(pin), .pad_i(pad_in), .pad_o(pad_out), .pad_oe_n_o(oe_n),
      .pad_ana_o(ana), .pad_ibuf_en_o(ibuf));
   pprm_pad_model u_pprm_pad_model (.pad_o_i(pad_out), .oe_n_i(oe_n), .ext_i(ext), .pad_i_o(pad_in));

   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic end_sim();
      if (n_mismatch == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_sim

   // one classic cycle; request held until ack is sampled high
   task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
      int k;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      for (k = 0; k < 20 && ack !== 1'b1; k++)
         @(posedge clk_i);
      if (ack !== 1'b1)
      begin
         n_mismatch++;
         end_sim();
      end
      else
      begin
         rdat = dat_o;
         cyc <= 1'b0;
         stb <= 1'b0;
         we <= 1'b0;
         @(posedge clk_i);
      end
   endtask : bus

   // peripheral line behind an output code, -1 for none or reserved
   function automatic int oline(int g, logic [3:0] c);
      if (g == 0)
         return (c == 1) ? 0 : (c == 2) ? 1 : (c == 3) ? 2 : (c == 5) ? 3 : (c == 7) ? 4 : -1;
      if (c == 3 || c == 4)
         return c + 2;
      if (g == 3)
         return (c == 5) ? 8 : (c == 6) ? 9 : (c == 7) ? 10 : -1;
      return (c == 5) ? 7 : -1;
   endfunction : oline

   initial
   begin
      int i, l;
      logic [31:0] e, m, lat, dir;
      e = $urandom(89655);
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(1'b0, PPRM_OUTSEL_OFS + 10'h07C, 0);
      chk(rdat, 32'h0000_0000);
      bus(1'b0, PPRM_BOOT_OFS, 0);
      chk(rdat, 32'h2000_0000);
      bus(1'b0, 10'h300, 0);
      chk(rdat, 32'h0000_0000);
      chk(oe_n, 32'hFFFF_FFFF);
      // input routing, first round forces codes 7 and 8
      for (int r = 0; r < 3; r++)
      begin
         for (i = 0; i < 24; i++)
         begin
            isel[i] = (r == 0 && i < 2) ? 4'(7 + i) : 4'($urandom_range(15));
            bus(1'b1, PPRM_INSEL_OFS + 10'(4 * i), 32'(isel[i]));
         end
         ext <= $urandom;
         repeat (3) @(posedge clk_i);
         for (i = 0; i < 24; i++)
            e[i] = (isel[i] < 8) ? ext[(i / 6) * 8 + isel[i]] : 1'b0;
         chk(32'(pin), {8'h00, e[23:0]});
         bus(1'b0, PPRM_VAL_OFS, 0);
         chk(rdat, ext);
      end
      // clock enable low: routed inputs hold although the pins move
      ce <= 1'b0;
      ext <= ~ext;
      repeat (3) @(posedge clk_i);
      chk(32'(pin), {8'h00, e[23:0]});
      ce <= 1'b1;
      // output map: every listed code in groups 0 and 3
      dir = $urandom;
      lat = $urandom;
      bus(1'b1, PPRM_DIR_OFS, dir);
      bus(1'b1, PPRM_LAT_OFS, lat);
      for (i = 0; i < 32; i++)
      begin
         osel[i] = (i % 24 < 8) ? 4'(i % 24) : 4'($urandom_range(15));
         bus(1'b1, PPRM_OUTSEL_OFS + 10'(4 * i), 32'(osel[i]));
      end
      pout <= pprm_periph_out_t'($urandom);
      repeat (2) @(posedge clk_i);
      for (i = 0; i < 32; i++)
      begin
         l = oline(i / 8, osel[i]);
         m[i] = (l < 0) ? dir[i] : ~pout.drive[l];
         e[i] = (l < 0) ? lat[i] : pout.data[l];
      end
      chk(oe_n, m);
      chk(pad_out & ~m, e & ~m);
      // lock: refused without unlock, then set and clear back to back
      bus(1'b1, PPRM_CFG_OFS, 32'h0000_2000);
      bus(1'b0, PPRM_CFG_OFS, 0);
      chk(rdat, 32'h0000_0000);
      unlock <= 1'b1;
      bus(1'b1, PPRM_CFG_OFS, 32'h0000_2000);
      bus(1'b1, PPRM_CFG_OFS, 32'h0000_0000);
      unlock <= 1'b0;
      bus(1'b0, PPRM_CFG_OFS, 0);
      chk(rdat, 32'h0000_2000);
      bus(1'b1, PPRM_OUTSEL_OFS, 32'(~osel[0]));
      bus(1'b0, PPRM_OUTSEL_OFS, 0);
      chk(rdat, 32'(osel[0]));
      // second reset with single-session off
      rst_i <= 1'b1;
      once <= 1'b0;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(1'b0, PPRM_OUTSEL_OFS, 0);
      chk(rdat, 32'h0000_0000);
      unlock <= 1'b1;
      bus(1'b1, PPRM_CFG_OFS, 32'h0000_2000);
      bus(1'b1, PPRM_CFG_OFS, 32'h0000_0000);
      unlock <= 1'b0;
      bus(1'b0, PPRM_CFG_OFS, 0);
      chk(rdat, 32'h0000_0000);
      // analog pin 3 beside digital pin 4, both mapped to line 0
      ana_v <= $urandom;
      ana_en <= $urandom & 32'hFFFF_FFEF; // pin 4 stays digital
      bus(1'b1, PPRM_DIR_OFS, 32'h0000_0000);
      bus(1'b1, PPRM_ANA_OFS, 32'h0000_0008);
      bus(1'b1, PPRM_CPC_OFS, 32'hFFFF_FFF7);
      bus(1'b1, PPRM_OUTSEL_OFS + 10'h00C, 32'h0000_0001);
      bus(1'b1, PPRM_OUTSEL_OFS + 10'h010, 32'h0000_0001);
      pout <= pprm_periph_out_t'(32'hFFFF_FFFF);
      repeat (2) @(posedge clk_i);
      chk(32'({ibuf[3], oe_n[3], oe_n[4]}), 32'h0000_0002);
      chk(ana, ana_v & ana_en);
      chk(oe_n & ana_en, ana_en);
      chk(ibuf, ~(ana_en | 32'h0000_0008));
      bus(1'b0, PPRM_VAL_OFS, 0);
      chk(rdat & 32'h0000_0008, 32'h0000_0000);
      end_sim();
   end
endmodule : pprm_tb_top

bind pprm_top pprm_checker #(.NPINS(NPINS), .NINPUT(NINPUT)) u_pprm_checker (
   .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .once_cfg_i(once_cfg_i), .pad_i(pad_i), .pad_oe_n_o(pad_oe_n_o),
   .pad_ibuf_en_o(pad_ibuf_en_o), .periph_in_o(periph_in_o));
`default_nettype wire
